// *** dka_regs.vh ***
// register offsets, field positions, reset values and key signatures
// for the debug key access block; included by the design file
`ifndef DKA_REGS_VH
`define DKA_REGS_VH
`define DKA_KEY_STATUS_OFS   8'h07
`define DKA_RESET_REQ_OFS    8'h08
`define DKA_SYS_CTRL_OFS     8'h0a
`define DKA_SYS_STATUS_OFS   8'h0b
`define DKA_LINK_CTRL_OFS    8'h10
`define DKA_KS_ERASE_BIT     3
`define DKA_KS_PROG_BIT      4
`define DKA_KS_UROW_BIT      5
`define DKA_SC_KEEPCLK_BIT   0
`define DKA_SC_ROWDONE_BIT   1
`define DKA_SS_LOCK_BIT      0
`define DKA_SS_ROWRDY_BIT    2
`define DKA_SS_PROGRDY_BIT   3
`define DKA_SS_SLEEP_BIT     4
`define DKA_SS_SYSRST_BIT    5
`define DKA_SS_EFAIL_BIT     6
`define DKA_LC_ENABLE_BIT    0
`define DKA_LC_INFO_BIT      1
`define DKA_SYS_CTRL_RST     8'h01
`define DKA_LINK_CTRL_RST    8'h01
`define DKA_RESET_SIG        8'h59
`define DKA_KEY_ERASE        64'h4e564d4572617365
`define DKA_KEY_PROG         64'h4e564d50726f6720
`define DKA_KEY_UROW         64'h4e564d5573267465
`define DKA_UROW_BYTES       32
`define DKA_INFO_BYTES       16
`endif

// *** dka_key_access.v ***
// debug key access control: key intake, info block readout, reset request,
// lock/erase status, user row buffer and sync-character event
// assumes system nvm/reset logic answers erase and copy with done pulses
//
// Contract
// - info block readable any time via info flag, regardless of lock.
// - every info block byte is an ascii character.
// - bytes 0-6 family, 7 reserved, 8-10 nvm, 11-13 debug, 14 rsvd, 15 osc.
// - 64-bit keys lsb first; activate only on exact signature match.
// - erase key plus reset request erases nvm and clears lock bits.
// - key status register shows a bit per activated key.
// - reset signature asserts system reset; writing 0x00 releases it.
// - lock status reads 1 while locked, 0 once erase finished.
// - erase failed bit reports erase outcome; zero means success.
// - while locked, system bus access from link refused.
// - user row key allows user row writes on locked device.
// - user row key plus reset pulse sets user row ready bit.
// - user row mode accepts writes to first 32 ram bytes, no reads.
// - buffered bytes copied one to one into user row.
// - done bit starts copy; ready bit clears when copy finishes.
// - one-cycle pulse event per rising edge within received sync character.
// - block only generates events, no event consumer inputs.
// - link stays alive in sleep; bus unavailable only with clock stopped.
// - status bit reads set while system is asleep.
// - keep system clock bit resets to 1; holds clock through sleep.
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "dka_regs.vh"
module dka_key_access #(
    parameter [55:0] FAMILY_IDENTIFIER = 56'h41424344454647, // arbitrary
    parameter [23:0] FIELD_A           = 24'h503030,         // arbitrary
    parameter [23:0] DEBUG_UNIT_VER    = 24'h443030,         // arbitrary
    parameter [7:0]  DEBUG_OSC_FREQ    = 8'h33               // arbitrary
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // avalon-mm register slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // key byte stream from link
    input  wire        key_byte_valid,
    input  wire [7:0]  key_byte,
    // info block readout
    input  wire        info_req,
    input  wire [3:0]  info_index,
    output reg  [7:0]  info_byte_ff,
    output reg         info_valid_ff,
    // system bus requests from link
    input  wire        link_bus_req,
    input  wire        link_bus_write,
    input  wire [15:0] link_bus_addr,
    output wire        link_bus_grant,
    output wire        ram_write_en,
    // system side
    input  wire        sys_clock_running,
    input  wire        sys_sleeping,
    input  wire        lock_bits_set,
    input  wire        erase_done,
    input  wire        erase_failed,
    input  wire        copy_done,
    output reg         sys_reset_ff,
    output reg         erase_start_ff,
    output reg         copy_start_ff,
    output wire        keep_system_clock,
    // sync character event
    input  wire        sync_char_active,
    input  wire        link_pin,
    output reg         sync_event_ff
);
    reg  [63:0] key_shift_ff;
    reg  [2:0]  key_cnt_ff;
    reg         erase_key_active_ff;
    reg         nvm_program_key_active_ff;
    reg         user_row_key_active_ff;
    reg         user_row_program_ready_ff;
    reg         nvm_prog_ready_ff;
    reg         erase_pending_ff;
    reg         erase_fail_ff;
    reg  [7:0]  reset_request_ff;
    reg  [7:0]  sys_ctrl_ff;
    reg  [7:0]  link_ctrl_ff;
    reg         rst_prev_ff;
    reg         pin_prev_ff;
    reg         ack_ff;
    wire        link_enable = link_ctrl_ff[`DKA_LC_ENABLE_BIT];
    wire        acc = (avs_read | avs_write) & ~ack_ff;
    // write lands on the edge where waitrequest is low
    wire        wr = avs_write & ack_ff & avs_byteenable[0];
    wire [7:0]  wd = avs_writedata[7:0];
    wire [63:0] key_full = {key_byte, key_shift_ff[63:8]};
    wire        key_last = key_byte_valid & (key_cnt_ff == 3'h7);
    wire        reset_rel = rst_prev_ff & ~sys_reset_ff;
    wire        device_locked_flag = lock_bits_set | erase_pending_ff;
    wire        ks_wr = wr & (avs_address == `DKA_KEY_STATUS_OFS);
    wire [7:0]  key_status_reg = {2'h0, user_row_key_active_ff,
                                  nvm_program_key_active_ff, erase_key_active_ff, 3'h0};
    wire [7:0]  system_status_reg = {1'h0, erase_fail_ff, sys_reset_ff, sys_sleeping,
                                     nvm_prog_ready_ff, user_row_program_ready_ff,
                                     1'h0, device_locked_flag};
    wire [127:0] system_info_block = {DEBUG_OSC_FREQ, 8'h20, DEBUG_UNIT_VER, FIELD_A,
                                      8'h20, FAMILY_IDENTIFIER};
    assign avs_waitrequest   = acc;
    assign keep_system_clock = sys_ctrl_ff[`DKA_SC_KEEPCLK_BIT];
    assign link_bus_grant = link_bus_req & sys_clock_running &
                            (user_row_program_ready_ff ?
                             (link_bus_write & (link_bus_addr < `DKA_UROW_BYTES)) :
                             ~device_locked_flag);
    assign ram_write_en = link_bus_grant & link_bus_write;
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            ack_ff       <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            ack_ff <= acc;
            if (avs_read & ~ack_ff)
            begin
                case (avs_address)
                    `DKA_KEY_STATUS_OFS: avs_readdata <= {24'h0, key_status_reg};
                    `DKA_RESET_REQ_OFS:  avs_readdata <= {24'h0, reset_request_ff};
                    `DKA_SYS_CTRL_OFS:   avs_readdata <= {24'h0, sys_ctrl_ff};
                    `DKA_SYS_STATUS_OFS: avs_readdata <= {24'h0, system_status_reg};
                    `DKA_LINK_CTRL_OFS:  avs_readdata <= {24'h0, link_ctrl_ff};
                    default:             avs_readdata <= 32'h0;
                endcase
            end
        end
    end
    // key intake and activation
    always @(posedge clk_sys)
    begin
        if (!resetn || !link_enable)
        begin
            key_shift_ff              <= 64'h0;
            key_cnt_ff                <= 3'h0;
            erase_key_active_ff       <= 1'b0;
            nvm_program_key_active_ff <= 1'b0;
            user_row_key_active_ff    <= 1'b0;
        end
        else
        begin
            if (key_byte_valid)
            begin
                key_shift_ff <= key_full;
                key_cnt_ff   <= key_cnt_ff + 3'h1;
            end
            if (key_last && key_full == `DKA_KEY_ERASE)
                erase_key_active_ff <= 1'b1;
            else if (reset_rel && erase_key_active_ff)
                erase_key_active_ff <= 1'b0;
            if (key_last && key_full == `DKA_KEY_PROG)
                nvm_program_key_active_ff <= 1'b1;
            if (key_last && key_full == `DKA_KEY_UROW)
                user_row_key_active_ff <= 1'b1;
            else if (ks_wr && wd[`DKA_KS_UROW_BIT])
                user_row_key_active_ff <= 1'b0;
        end
    end
    // reset request, erase and program modes
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            reset_request_ff          <= 8'h00;
            sys_reset_ff              <= 1'b0;
            rst_prev_ff               <= 1'b0;
            erase_start_ff            <= 1'b0;
            erase_pending_ff          <= 1'b0;
            erase_fail_ff             <= 1'b0;
            nvm_prog_ready_ff         <= 1'b0;
            user_row_program_ready_ff <= 1'b0;
            copy_start_ff             <= 1'b0;
            sys_ctrl_ff               <= `DKA_SYS_CTRL_RST;
            link_ctrl_ff              <= `DKA_LINK_CTRL_RST;
        end
        else
        begin
            rst_prev_ff    <= sys_reset_ff;
            erase_start_ff <= 1'b0;
            copy_start_ff  <= 1'b0;
            if (wr && avs_address == `DKA_RESET_REQ_OFS)
            begin
                reset_request_ff <= wd;
                sys_reset_ff     <= (wd == `DKA_RESET_SIG);
            end
            if (wr && avs_address == `DKA_LINK_CTRL_OFS)
                link_ctrl_ff <= wd;
            if (wr && avs_address == `DKA_SYS_CTRL_OFS)
                sys_ctrl_ff <= {6'h0, wd[`DKA_SC_ROWDONE_BIT], wd[`DKA_SC_KEEPCLK_BIT]};
            if (!link_enable)
                sys_ctrl_ff[`DKA_SC_KEEPCLK_BIT] <= 1'b1;
            if (reset_rel && erase_key_active_ff)
            begin
                erase_start_ff   <= 1'b1;
                erase_pending_ff <= 1'b1;
            end
            else if (erase_done)
            begin
                erase_pending_ff <= 1'b0;
                erase_fail_ff    <= erase_failed;
            end
            if (reset_rel)
                nvm_prog_ready_ff <= nvm_program_key_active_ff & ~lock_bits_set;
            if (reset_rel && user_row_key_active_ff && !user_row_program_ready_ff)
                user_row_program_ready_ff <= 1'b1;
            else if (copy_done || !link_enable)
                user_row_program_ready_ff <= 1'b0;
            if (user_row_program_ready_ff && sys_ctrl_ff[`DKA_SC_ROWDONE_BIT])
            begin
                copy_start_ff <= 1'b1;
                sys_ctrl_ff[`DKA_SC_ROWDONE_BIT] <= 1'b0;
            end
        end
    end
    // info block readout and sync event
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            info_byte_ff  <= 8'h00;
            info_valid_ff <= 1'b0;
            pin_prev_ff   <= 1'b0;
            sync_event_ff <= 1'b0;
        end
        else
        begin
            info_valid_ff <= info_req;
            if (info_req)
                info_byte_ff <= system_info_block[{info_index, 3'h0} +: 8];
            pin_prev_ff   <= link_pin;
            sync_event_ff <= sync_char_active & link_pin & ~pin_prev_ff;
        end
    end
endmodule // dka_key_access

// *** dka_key_access_assertions.sv ***
// port assertions for the debug key access block
// assumes the block runs on clk_sys with resetn synchronous active low
`timescale 1ns/1ps
module dka_key_access_chk (
    // clock, reset and register bus
    input wire        clk_sys, resetn, avs_read, avs_write, avs_waitrequest,
    // info readout and system side
    input wire        info_req, info_valid_ff, lock_bits_set, sys_clock_running,
    input wire        erase_start_ff, copy_start_ff,
    // link bus
    input wire        link_bus_write, link_bus_grant,
    input wire [15:0] link_bus_addr,
    // sync event
    input wire        sync_char_active, link_pin, sync_event_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_rise; sync_char_active && $rose(link_pin); endsequence
    chk_one_wait: assert property (s_req |=> !avs_waitrequest)
        else $error("access not answered after one wait");
    chk_info_next: assert property (info_req |=> info_valid_ff)
        else $error("info byte late");
    chk_lock_read: assert property (lock_bits_set && !link_bus_write |-> !link_bus_grant)
        else $error("read granted while locked");
    chk_urow_range: assert property (lock_bits_set && link_bus_addr > 16'h001f
        |-> !link_bus_grant) else $error("write beyond buffer granted");
    chk_clk_stop: assert property (!sys_clock_running |-> !link_bus_grant)
        else $error("grant with system clock stopped");
    chk_erase_pulse: assert property (erase_start_ff |=> !erase_start_ff)
        else $error("erase start not a pulse");
    chk_copy_pulse: assert property (copy_start_ff |=> !copy_start_ff)
        else $error("copy start not a pulse");
    chk_sync_edge: assert property (s_rise |=> sync_event_ff)
        else $error("sync edge without event");
    chk_sync_once: assert property (sync_event_ff |=> !sync_event_ff)
        else $error("sync event too long");
endmodule // dka_key_access_chk
bind dka_key_access dka_key_access_chk dka_key_access_chk_inst (
    .clk_sys(clk_sys), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .info_req(info_req), .info_valid_ff(info_valid_ff),
    .lock_bits_set(lock_bits_set), .sys_clock_running(sys_clock_running),
    .erase_start_ff(erase_start_ff), .copy_start_ff(copy_start_ff),
    .link_bus_write(link_bus_write), .link_bus_grant(link_bus_grant),
    .link_bus_addr(link_bus_addr), .sync_char_active(sync_char_active),
    .link_pin(link_pin), .sync_event_ff(sync_event_ff));

// *** dka_sys_model.sv ***
// stand-in for the system nvm erase and user row copy engines
// answers each start pulse four cycles later; device starts locked
`timescale 1ns/1ps
module dka_sys_model (
    // clock and reset
    input  wire clk_sys, resetn,
    // start pulses in, done pulses and lock state out
    input  wire erase_start_ff, copy_start_ff,
    output reg  lock_bits_set, erase_done, copy_done
);
    reg [2:0] er_ff, cp_ff;
    always @(posedge clk_sys)
    begin
        er_ff <= resetn ? {er_ff[1:0], erase_start_ff} : 3'h0;
        cp_ff <= resetn ? {cp_ff[1:0], copy_start_ff} : 3'h0;
        erase_done <= er_ff[2];
        copy_done <= cp_ff[2];
        lock_bits_set <= !resetn | (lock_bits_set & !er_ff[2]);
    end
endmodule // dka_sys_model

// *** dka_key_access_tb.sv ***
// testbench for the debug key access block
// avalon master tasks, key stream and link bus probes; system model alongside
`timescale 1ns/1ps
`include "dka_regs.vh"
module dka_key_access_tb;
    localparam [127:0] INFO_EXP = {8'h33, 8'h20, 24'h443030, 24'h503030, 8'h20,
                                   56'h41424344454647};
    reg         clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0, key_byte_valid = 0;
    reg         info_req = 0, link_bus_req = 0, link_bus_write = 0, sys_sleeping = 0;
    reg         sys_clock_running = 1, sync_char_active = 0, link_pin = 0, erase_failed = 0;
    reg  [7:0]  avs_address = 0, key_byte = 0;
    reg  [3:0]  info_index = 0;
    reg  [15:0] link_bus_addr = 0;
    reg  [31:0] avs_writedata = 0, rdat;
    wire [31:0] avs_readdata;
    wire [7:0]  info_byte_ff;
    wire        avs_waitrequest, info_valid_ff, link_bus_grant, ram_write_en, lock_bits_set;
    wire        erase_done, copy_done, sys_reset_ff, erase_start_ff, copy_start_ff;
    wire        keep_system_clock, sync_event_ff;
    integer     errors = 0, n_tests = 0, cyc = 0, nev = 0, i;
    dka_key_access #(.FAMILY_IDENTIFIER(INFO_EXP[55:0]), .FIELD_A(INFO_EXP[87:64]),
        .DEBUG_UNIT_VER(INFO_EXP[111:88]), .DEBUG_OSC_FREQ(INFO_EXP[127:120]))
        dka_key_access_inst (
        .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .key_byte_valid(key_byte_valid),
        .key_byte(key_byte), .info_req(info_req), .info_index(info_index),
        .info_byte_ff(info_byte_ff), .info_valid_ff(info_valid_ff),
        .link_bus_req(link_bus_req), .link_bus_write(link_bus_write),
        .link_bus_addr(link_bus_addr), .link_bus_grant(link_bus_grant),
        .ram_write_en(ram_write_en), .sys_clock_running(sys_clock_running),
        .sys_sleeping(sys_sleeping), .lock_bits_set(lock_bits_set),
        .erase_done(erase_done), .erase_failed(erase_failed), .copy_done(copy_done),
        .sys_reset_ff(sys_reset_ff), .erase_start_ff(erase_start_ff),
        .copy_start_ff(copy_start_ff), .keep_system_clock(keep_system_clock),
        .sync_char_active(sync_char_active), .link_pin(link_pin),
        .sync_event_ff(sync_event_ff));
    dka_sys_model dka_sys_model_inst (
        .clk_sys(clk_sys), .resetn(resetn), .erase_start_ff(erase_start_ff),
        .copy_start_ff(copy_start_ff), .lock_bits_set(lock_bits_set),
        .erase_done(erase_done), .copy_done(copy_done));
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (sync_event_ff === 1'b1)
            nev <= nev + 1;
        if (cyc == 6000)
        begin
            errors = errors + 1;
            $display("unexpected %0t timeout", $time);
            stop_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("unexpected %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task acc(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            avs_address <= a; avs_writedata <= {24'h0, d}; avs_read <= !w; avs_write <= w;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
            rdat = avs_readdata; avs_read <= 0; avs_write <= 0;
        end
    endtask
    task key(input [63:0] k);
        for (i = 0; i < 9; i = i + 1)
        begin
            @(posedge clk_sys);
            key_byte_valid <= i < 8; key_byte <= k[8*(i%8) +: 8];
        end
    endtask
    task pulse;
        begin
            acc(1, 8'h08, `DKA_RESET_SIG); @(negedge clk_sys);
            chk(sys_reset_ff, 1);
            acc(1, 8'h08, 8'h00); @(negedge clk_sys);
            chk(sys_reset_ff, 0);
        end
    endtask
    task poll(input [2:0] b, input v);
        begin
            acc(0, 8'h0b, 0);
            for (i = 0; i < 40 && rdat[b] !== v; i = i + 1) acc(0, 8'h0b, 0);
            chk(rdat[b], v);
        end
    endtask
    task lb(input w, input [15:0] a, input exp);
        begin
            @(posedge clk_sys); link_bus_req <= 1; link_bus_write <= w; link_bus_addr <= a;
            @(negedge clk_sys); chk(link_bus_grant, exp); chk(ram_write_en, exp & w);
            @(posedge clk_sys); link_bus_req <= 0;
        end
    endtask
    task t_reset;
        begin
            acc(0, 8'h07, 0); chk(rdat, 0);
            acc(0, 8'h0a, 0); chk(rdat, 1);
            chk(keep_system_clock, 1);
            acc(0, 8'h3c, 0); chk(rdat, 0);
            key(`DKA_KEY_ERASE ^ 64'h100); acc(0, 8'h07, 0); chk(rdat, 0);
            for (i = 0; i < 16; i = i + 1)
            begin
                @(posedge clk_sys); info_req <= 1; info_index <= i[3:0];
                @(posedge clk_sys); info_req <= 0; @(negedge clk_sys);
                chk(info_valid_ff, 1);
                chk(info_byte_ff[7], 0);
                if (i != 7 && i != 14) chk(info_byte_ff, INFO_EXP[8*i +: 8]);
            end
            $display("test reset and info done");
        end
    endtask
    task t_urow;
        begin
            key(`DKA_KEY_UROW); acc(0, 8'h07, 0); chk(rdat, 32'h20);
            pulse; poll(2, 1);
            lb(1, 16'h001f, 1);
            lb(1, 16'h0020, 0);
            lb(0, 16'h0000, 0);
            acc(1, 8'h0a, 8'h03); poll(2, 0);
            acc(1, 8'h07, 8'h20); acc(0, 8'h07, 0); chk(rdat, 0);
            pulse;
            $display("test user row done");
        end
    endtask
    task t_erase;
        begin
            key(`DKA_KEY_ERASE); acc(0, 8'h07, 0); chk(rdat, 32'h08);
            pulse; poll(0, 0);
            chk(rdat[6], 0);
            lb(0, 16'h0100, 1);
            key(`DKA_KEY_PROG); pulse; poll(3, 1);
            pulse;
            key(`DKA_KEY_ERASE); erase_failed <= 1; pulse; poll(0, 0);
            chk(rdat[6], 1);
            erase_failed <= 0;
            $display("test erase and program done");
        end
    endtask
    task t_misc;
        begin
            @(posedge clk_sys); sys_sleeping <= 1;
            acc(0, 8'h0b, 0); chk(rdat[4], 1);
            lb(0, 16'h0100, 1);
            sys_clock_running <= 0; lb(0, 16'h0100, 0);
            sys_clock_running <= 1; sys_sleeping <= 0; sync_char_active <= 1;
            for (i = 0; i < 6; i = i + 1) @(posedge clk_sys) link_pin <= !link_pin;
            repeat (2) @(posedge clk_sys);
            sync_char_active <= 0; @(negedge clk_sys); chk(nev, 3);
            acc(1, 8'h0a, 8'h00); @(negedge clk_sys);
            chk(keep_system_clock, 0);
            key(`DKA_KEY_PROG); acc(1, 8'h10, 8'h00);
            acc(0, 8'h07, 0); chk(rdat, 0);
            chk(keep_system_clock, 1);
            acc(1, 8'h10, 8'h01);
            $display("test sleep, sync and disable done");
        end
    endtask
    task stop_test;
        begin
            $display("tests %0d errors %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1;
        t_reset; t_urow; t_erase; t_misc;
        stop_test;
    end
endmodule // dka_key_access_tb
